/* File: inc/adc_ctrl_pkg.sv */
// Package: register map, field layout and timing constants for the converter control
// Summary of operation
// [R1] Six-bit channel field in control A bits 7..2 routes codes 0..31; 63 selects nothing.
// [R2] Smaller package treats channel codes 6 and 7 as not implemented.
// [R3] Writing one to go bit (control A bit 1) starts a conversion.
// [R4] Go bit clears itself when the conversion finishes.
// [R5] Go bit reads one while converting, zero otherwise.
// [R6] Control A bit 0 enables the converter; zero disables it and gates it off.
// [R7] Control B bits 6..4 pick bit clock: /8, /16, /32, /64 or RC; 000 and 100 reserved.
// [R8] RC clock option divides the internal oscillator by 16.
// [R9] Control B bit 2 selects right justify when one, left when zero.
// [R10] Control B bits 1..0 choose reference: external pin, supply or internal.
// [R11] Unimplemented bits read zero and ignore writes.
// [R12] Right justify: result high bits 1..0 hold result bits 9..8.
// [R13] Right justify: result low holds result bits 7..0.
// [R14] Software waits an acquisition period after a channel change before starting.
// [R15] A conversion lasts eleven bit periods from start until go clears.
// [R16] Done flag sets on every conversion end and stays until software clears it.
// [R17] Clearing go early abandons the conversion; results keep the previous value.
// [R18] After an abort, wait two bit periods, then start a new acquisition.
// [R19] Left justify: high holds bits 9..2, low bits 7..6 hold bits 1..0.
// [R20] Go writes are ignored while disabled; clearing enable aborts a conversion.
package adc_ctrl_pkg;
  localparam logic [3:0] OFS_CONTROL_A = 4'h0;
  localparam logic [3:0] OFS_CONTROL_B = 4'h4;
  localparam logic [3:0] OFS_RESULT_HIGH = 4'h8;
  localparam logic [3:0] OFS_RESULT_LOW = 4'hC;
  localparam logic [3:0] OFS_DONE_FLAG = 4'h0;
  localparam logic [7:0] CONTROL_A_RESET = 8'h00;
  localparam logic [7:0] CONTROL_B_RESET = 8'h00;
  localparam logic [7:0] CONTROL_B_MASK = 8'h77;
  localparam int CA_ENABLE_BIT = 0;
  localparam int CA_GO_BIT = 1;
  localparam int CA_CHAN_LSB = 2;
  localparam int CB_JUSTIFY_BIT = 2;
  localparam int CB_CLKSEL_LSB = 4;
  localparam int FLAG_BIT = 0;
  localparam logic [5:0] CHAN_LAST_VALID = 6'h1F;
  localparam logic [5:0] CHAN_SMALL_GAP_A = 6'h06;
  localparam logic [5:0] CHAN_SMALL_GAP_B = 6'h07;
  localparam logic [2:0] CLK_DIV8 = 3'h1;
  localparam logic [2:0] CLK_DIV16 = 3'h5;
  localparam logic [2:0] CLK_DIV32 = 3'h2;
  localparam logic [2:0] CLK_DIV64 = 3'h6;
  localparam int RC_DIVIDE = 16;
  localparam int CONV_PERIODS = 11;
  localparam int ABORT_PERIODS = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONVERT = 2'b01,
    ST_HOLDOFF = 2'b10
  } conv_state_t;
endpackage

/* File: rtl/bit_clock_gen.sv */
// Conversion bit period tick generator from system clock or RC oscillator
`timescale 1ns/1ps
module bit_clock_gen
  import adc_ctrl_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic run,
  input wire logic [2:0] clockSelect,
  input wire logic rcOsc,
  output logic bitTick
);
  logic [5:0] divCount_reg;
  logic [5:0] divCount_next;
  logic [5:0] divLast;
  logic rcMeta_reg;
  logic rcSync_reg;
  logic rcDly_reg;
  logic rcEdge;
  logic [3:0] rcCount_reg;
  logic isRc;
  logic reserved;
  logic sysTick;
  logic rcTick;

  ////////////////////////////////////////////////////////////////////
  // Divider end count per select code; reserved codes never tick
  assign isRc = (clockSelect[1:0] == 2'b11); // R7
  assign reserved = (clockSelect[1:0] == 2'b00); // R7
  assign divLast = (clockSelect == CLK_DIV8) ? 6'h07 :
                   (clockSelect == CLK_DIV16) ? 6'h0F :
                   (clockSelect == CLK_DIV32) ? 6'h1F : 6'h3F; // R7
  assign sysTick = run && !isRc && !reserved && (divCount_reg == divLast);
  assign divCount_next = (!run || sysTick) ? 6'h00 : divCount_reg + 6'h01;
  // RC oscillator is asynchronous; edge found after two flops
  assign rcEdge = rcSync_reg && !rcDly_reg;
  assign rcTick = run && isRc && rcEdge && (rcCount_reg == 4'(RC_DIVIDE - 1)); // R8
  assign bitTick = sysTick || rcTick;

  // Counters
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      divCount_reg <= 6'h00;
      rcMeta_reg <= 1'b0;
      rcSync_reg <= 1'b0;
      rcDly_reg <= 1'b0;
      rcCount_reg <= 4'h0;
    end else begin
      divCount_reg <= divCount_next;
      rcMeta_reg <= rcOsc;
      rcSync_reg <= rcMeta_reg;
      rcDly_reg <= rcSync_reg;
      if (!run) begin
        rcCount_reg <= 4'h0;
      end else if (rcEdge) begin
        rcCount_reg <= rcCount_reg + 4'h1; // R8
      end
    end
  end
endmodule // bit_clock_gen

/* File: rtl/sar_engine.sv */
// Successive approximation sequencer against an external comparator
`timescale 1ns/1ps
module sar_engine #(
  parameter int WIDTH = 10
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic start,
  input wire logic step,
  input wire logic compareHigh,
  output logic [WIDTH-1:0] trialCode,
  output logic [WIDTH-1:0] finalCode
);
  logic [WIDTH-1:0] mask_reg;
  logic [WIDTH-1:0] code_reg;

  ////////////////////////////////////////////////////////////////////
  // Trial code is the kept bits plus the bit under test
  assign trialCode = code_reg | mask_reg;
  assign finalCode = code_reg;

  // One bit decided per step, MSB first
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      mask_reg <= '0;
      code_reg <= '0;
    end else if (start) begin
      mask_reg <= {1'b1, {(WIDTH-1){1'b0}}};
      code_reg <= '0;
    end else if (step && mask_reg != '0) begin
      if (compareHigh) begin
        code_reg <= code_reg | mask_reg;
      end
      mask_reg <= mask_reg >> 1;
    end
  end
endmodule // sar_engine

/* File: rtl/adc_conversion_control.sv */
// Converter control block with AXI4-Lite register slave
`timescale 1ns/1ps
module adc_conversion_control #(
  parameter bit SMALL_PACKAGE = 1'b0
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic flagSel,
  input wire logic rcOsc,
  input wire logic compareIn,
  output logic [5:0] channelRoute,
  output logic channelValid,
  output logic [1:0] referenceSelect,
  output logic analogPower,
  output logic sampleHold,
  output logic [9:0] dacCode,
  output logic conversionDoneFlag
);
  import adc_ctrl_pkg::*;

  logic [7:0] controlA_reg;
  logic [7:0] controlB_reg;
  logic [9:0] result_reg;
  logic flag_reg;
  conv_state_t state_reg;
  conv_state_t state_next;
  logic [3:0] periods_reg;
  logic [3:0] periods_next;
  logic awHeld_reg;
  logic wHeld_reg;
  logic [3:0] awAddr_reg;
  logic [7:0] wData_reg;
  logic wStrb0_reg;
  logic bValid_reg;
  logic rValid_reg;
  logic [31:0] rData_reg;
  logic [1:0] rResp_reg;
  logic [1:0] bResp_reg;
  logic cmpMeta_reg;
  logic cmpSync_reg;
  logic bitTick;
  logic [9:0] trialCode;
  logic [9:0] finalCode;
  logic doWrite;
  logic wrHit;
  logic wrA;
  logic wrB;
  logic wrFlag;
  logic rdTake;
  logic rdHit;
  logic goWritten;
  logic goRequest;
  logic abortReq;
  logic startConv;
  logic convEnd;
  logic converting;
  logic [7:0] resultHigh;
  logic [7:0] resultLow;
  logic [7:0] rdByte;
  logic enable;
  logic [5:0] chanField;

  ////////////////////////////////////////////////////////////////////
  // Register decode helper
  function automatic logic is_mapped(input logic [3:0] addr, input logic flagSpace);
    if (flagSpace) begin
      is_mapped = (addr == OFS_DONE_FLAG);
    end else begin
      is_mapped = (addr == OFS_CONTROL_A) || (addr == OFS_CONTROL_B) ||
                  (addr == OFS_RESULT_HIGH) || (addr == OFS_RESULT_LOW);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  // AXI write side: address and data taken in either order
  assign s_axi_awready = !awHeld_reg && !bValid_reg;
  assign s_axi_wready = !wHeld_reg && !bValid_reg;
  assign doWrite = awHeld_reg && wHeld_reg && !bValid_reg;
  assign wrHit = doWrite && wStrb0_reg && is_mapped(awAddr_reg, flagSel);
  assign wrA = wrHit && !flagSel && (awAddr_reg == OFS_CONTROL_A);
  assign wrB = wrHit && !flagSel && (awAddr_reg == OFS_CONTROL_B);
  assign wrFlag = wrHit && flagSel;
  assign s_axi_bvalid = bValid_reg;
  assign s_axi_bresp = bResp_reg;

  // Write channel latches
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      awHeld_reg <= 1'b0;
      wHeld_reg <= 1'b0;
      awAddr_reg <= 4'h0;
      wData_reg <= 8'h00;
      wStrb0_reg <= 1'b0;
      bValid_reg <= 1'b0;
      bResp_reg <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_reg <= 1'b1;
        awAddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_reg <= 1'b1;
        wData_reg <= s_axi_wdata[7:0];
        wStrb0_reg <= s_axi_wstrb[0];
      end
      if (doWrite) begin
        awHeld_reg <= 1'b0;
        wHeld_reg <= 1'b0;
        bValid_reg <= 1'b1;
        bResp_reg <= is_mapped(awAddr_reg, flagSel) ? RESP_OKAY : RESP_SLVERR;
      end else if (bValid_reg && s_axi_bready) begin
        bValid_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Conversion sequencing
  assign enable = controlA_reg[CA_ENABLE_BIT];
  assign converting = (state_reg == ST_CONVERT);
  assign goWritten = wrA && wData_reg[CA_GO_BIT];
  assign goRequest = goWritten && wData_reg[CA_ENABLE_BIT] && enable; // R20
  assign abortReq = converting && ((wrA && !wData_reg[CA_GO_BIT]) ||
                    (wrA && !wData_reg[CA_ENABLE_BIT])); // R17 R20
  assign startConv = (state_reg == ST_IDLE) && goRequest; // R3
  assign convEnd = converting && !abortReq && bitTick &&
                   (periods_reg == 4'(CONV_PERIODS - 1)); // R15

  // Next state
  always_comb begin
    state_next = state_reg;
    periods_next = periods_reg;
    case (state_reg)
      ST_IDLE: begin
        periods_next = 4'h0;
        if (startConv) begin
          state_next = ST_CONVERT;
        end
      end
      ST_CONVERT: begin
        if (abortReq) begin
          state_next = ST_HOLDOFF; // R17
          periods_next = 4'h0;
        end else if (convEnd) begin
          state_next = ST_IDLE; // R4
          periods_next = 4'h0;
        end else if (bitTick) begin
          periods_next = periods_reg + 4'h1;
        end
      end
      ST_HOLDOFF: begin
        // Two periods blanked while enabled, then acquisition resumes on the channel; disable leaves at once
        if (!enable) begin
          state_next = ST_IDLE;
        end else if (bitTick && periods_reg == 4'(ABORT_PERIODS - 1)) begin
          state_next = ST_IDLE; // R18
        end else if (bitTick) begin
          periods_next = periods_reg + 4'h1;
        end
      end
      default: begin
        state_next = ST_IDLE;
        periods_next = 4'h0;
      end
    endcase
  end

  // Control registers, result and flag
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      controlA_reg <= CONTROL_A_RESET;
      controlB_reg <= CONTROL_B_RESET;
      state_reg <= ST_IDLE;
      periods_reg <= 4'h0;
      flag_reg <= 1'b0;
      result_reg <= 10'h000;
    end else begin
      state_reg <= state_next;
      periods_reg <= periods_next;
      if (wrA) begin
        controlA_reg[7:2] <= wData_reg[7:2]; // R1
        controlA_reg[CA_ENABLE_BIT] <= wData_reg[CA_ENABLE_BIT]; // R6
      end
      if (wrB) begin
        controlB_reg <= wData_reg & CONTROL_B_MASK; // R11
      end
      // Last bit is decided on this same edge, so take it from the comparator here
      if (convEnd) begin
        result_reg <= cmpSync_reg ? trialCode : finalCode; // R17
      end
      if (convEnd) begin
        flag_reg <= 1'b1; // R16
      end else if (wrFlag && !wData_reg[FLAG_BIT]) begin
        flag_reg <= 1'b0;
      end
    end
  end

  // Go bit is not stored; reads show the running conversion instead

  ////////////////////////////////////////////////////////////////////
  // Comparator synchroniser and engines
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cmpMeta_reg <= 1'b0;
      cmpSync_reg <= 1'b0;
    end else begin
      cmpMeta_reg <= compareIn;
      cmpSync_reg <= cmpMeta_reg;
    end
  end

  bit_clock_gen u_clk (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .run(state_reg != ST_IDLE),
    .clockSelect(controlB_reg[6:4]), // R7
    .rcOsc(rcOsc),
    .bitTick(bitTick)
  );

  sar_engine #(.WIDTH(10)) u_sar (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .start(startConv),
    .step(converting && bitTick && periods_reg != 4'h0),
    .compareHigh(cmpSync_reg),
    .trialCode(trialCode),
    .finalCode(finalCode)
  );

  ////////////////////////////////////////////////////////////////////
  // Analog side controls
  assign chanField = controlA_reg[7:2];
  assign channelValid = enable && (chanField <= CHAN_LAST_VALID) &&
                        !(SMALL_PACKAGE && (chanField == CHAN_SMALL_GAP_A ||
                          chanField == CHAN_SMALL_GAP_B)); // R1 R2
  assign channelRoute = chanField;
  assign referenceSelect = controlB_reg[1:0]; // R10
  assign analogPower = enable; // R6
  assign sampleHold = converting;
  assign dacCode = trialCode;
  assign conversionDoneFlag = flag_reg;

  ////////////////////////////////////////////////////////////////////
  // Result formatting for reads
  assign resultHigh = controlB_reg[CB_JUSTIFY_BIT] ? {6'h00, result_reg[9:8]} // R9 R12 R11
                                                   : result_reg[9:2]; // R19
  assign resultLow = controlB_reg[CB_JUSTIFY_BIT] ? result_reg[7:0] // R13
                                                  : {result_reg[1:0], 6'h00}; // R19
  assign rdByte = flagSel ? {7'h00, flag_reg} :
                  (s_axi_araddr == OFS_CONTROL_A) ?
                    {controlA_reg[7:2], converting, controlA_reg[0]} : // R5
                  (s_axi_araddr == OFS_CONTROL_B) ? controlB_reg :
                  (s_axi_araddr == OFS_RESULT_HIGH) ? resultHigh : resultLow;

  ////////////////////////////////////////////////////////////////////
  // AXI read side: one read outstanding, data from a register
  assign s_axi_arready = !rValid_reg;
  assign rdTake = s_axi_arvalid && s_axi_arready;
  assign rdHit = is_mapped(s_axi_araddr, flagSel);
  assign s_axi_rvalid = rValid_reg;
  assign s_axi_rdata = rData_reg;
  assign s_axi_rresp = rResp_reg;

  // Read response
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rValid_reg <= 1'b0;
      rData_reg <= 32'h0000_0000;
      rResp_reg <= RESP_OKAY;
    end else if (rdTake) begin
      rValid_reg <= 1'b1;
      rData_reg <= rdHit ? {24'h000000, rdByte} : 32'h0000_0000;
      rResp_reg <= rdHit ? RESP_OKAY : RESP_SLVERR;
    end else if (rValid_reg && s_axi_rready) begin
      rValid_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Checks
  a_go_ignored_off: assert property (@(posedge sys_clk) disable iff (!rstn) // R20
    (goWritten && !enable && state_reg == ST_IDLE) |=> state_reg == ST_IDLE)
    else $error("go accepted while disabled");
  a_go_starts: assert property (@(posedge sys_clk) disable iff (!rstn) // R3
    startConv |=> converting)
    else $error("go did not start conversion");
  a_go_clears: assert property (@(posedge sys_clk) disable iff (!rstn) // R4
    convEnd |=> state_reg == ST_IDLE)
    else $error("go not cleared after conversion");
  a_done_flag_set: assert property (@(posedge sys_clk) disable iff (!rstn) // R16
    convEnd |=> flag_reg)
    else $error("done flag not set");
  a_result_kept: assert property (@(posedge sys_clk) disable iff (!rstn) // R17
    abortReq |=> $stable(result_reg))
    else $error("result changed on abort");
  a_abort_holdoff: assert property (@(posedge sys_clk) disable iff (!rstn) // R18
    (abortReq && wData_reg[CA_ENABLE_BIT]) |=> state_reg == ST_HOLDOFF)
    else $error("no holdoff after abort");
  a_unimpl_zero: assert property (@(posedge sys_clk) disable iff (!rstn) // R11
    controlB_reg[7] == 1'b0 && controlB_reg[3] == 1'b0)
    else $error("unimplemented bits set");
  a_right_high: assert property (@(posedge sys_clk) disable iff (!rstn) // R12
    controlB_reg[CB_JUSTIFY_BIT] |-> resultHigh[7:2] == 6'h00)
    else $error("high result upper bits nonzero");
  a_power_gates_hold: assert property (@(posedge sys_clk) disable iff (!rstn) // R6 R20
    !analogPower |-> !sampleHold)
    else $error("converting while disabled");
  c_full_conv: cover property (@(posedge sys_clk) disable iff (!rstn) convEnd);
  c_abort: cover property (@(posedge sys_clk) disable iff (!rstn) abortReq);
  c_holdoff_done: cover property (@(posedge sys_clk) disable iff (!rstn)
    state_reg == ST_HOLDOFF ##1 state_reg == ST_IDLE);
endmodule // adc_conversion_control

/* File: test/adc_conversion_control_tb_top.sv */
// Self-checking bench for the converter control block over AXI4-Lite
`timescale 1ns/1ps
module adc_conversion_control_tb_top;
  import adc_ctrl_pkg::*;
  logic sys_clk = 1'h0, rstn = 1'h0, flagSel = 1'h0, rcOsc = 1'h0, compareIn = 1'h0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic sampleHold, analogPower, channelValid, conversionDoneFlag;
  logic [1:0] s_axi_bresp, s_axi_rresp, referenceSelect;
  logic [5:0] channelRoute;
  logic [9:0] dacCode;
  int miscompares = 0, comparisons = 0, cycleNow = 0;

  adc_conversion_control #(.SMALL_PACKAGE(1'b0)) u_dut (
    .sys_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .flagSel, .rcOsc, .compareIn, .channelRoute, .channelValid,
    .referenceSelect, .analogPower, .sampleHold, .dacCode, .conversionDoneFlag
  );

  // Small package copy shares every input; only its route-valid output is judged
  logic smallValid;
  adc_conversion_control #(.SMALL_PACKAGE(1'b1)) u_dut_small (
    .sys_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready(), .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(),
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready(), .s_axi_rdata(),
    .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready, .flagSel, .rcOsc, .compareIn,
    .channelRoute(), .channelValid(smallValid), .referenceSelect(), .analogPower(),
    .sampleHold(), .dacCode(), .conversionDoneFlag()
  );

  ////////////////////////////////////////////////////////////////
  // Clock, cycle count and a slow RC oscillator (8 cycles a period)
  initial forever #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cycleNow <= cycleNow + 1;
  initial forever begin
    repeat (4) @(posedge sys_clk);
    rcOsc <= ~rcOsc;
  end

  // Watchdog, far above the few thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    close_out();
  end

  ////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    if (miscompares == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Ready sampled at the falling edge is what the next rising edge takes
  task automatic axi_wr(input logic fs, input logic [3:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    logic aw, w, b;
    int n;
    @(posedge sys_clk);
    flagSel <= fs;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    b = 1'h0;
    n = 0;
    while (!b && n < 100) begin
      @(negedge sys_clk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = (s_axi_bvalid === 1'h1);
      r = s_axi_bresp;
      @(posedge sys_clk);
      if (aw) s_axi_awvalid <= 1'h0;
      if (w) s_axi_wvalid <= 1'h0;
      if (b) s_axi_bready <= 1'h0;
      n++;
    end
    check("write answered", 32'(b), 32'h1);
  endtask

  task automatic axi_rd(input logic fs, input logic [3:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    logic ar, got;
    int n;
    @(posedge sys_clk);
    flagSel <= fs;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    got = 1'h0;
    n = 0;
    while (!got && n < 100) begin
      @(negedge sys_clk);
      ar = s_axi_arvalid && s_axi_arready;
      got = (s_axi_rvalid === 1'h1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge sys_clk);
      if (ar) s_axi_arvalid <= 1'h0;
      if (got) s_axi_rready <= 1'h0;
      n++;
    end
    check("read answered", 32'(got), 32'h1);
  endtask

  task automatic rd_chk(input logic fs, input logic [3:0] a, input logic [31:0] exp,
                        input string what);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(fs, a, d, r);
    check(what, d, exp);
  endtask

  ////////////////////////////////////////////////////////////////
  // One conversion on channel 0; result, flag and duration judged here
  task automatic conv_case(input logic [2:0] clk, input logic j, input int p,
                           input logic [7:0] hi, input logic [7:0] lo);
    logic [31:0] d;
    logic [1:0] r;
    int t0, n;
    axi_wr(1'h0, OFS_CONTROL_B, (32'(clk) << CB_CLKSEL_LSB) | (32'(j) << CB_JUSTIFY_BIT), r);
    axi_wr(1'h0, OFS_CONTROL_A, 32'h1, r);
    repeat (10) @(posedge sys_clk);
    axi_wr(1'h0, OFS_CONTROL_A, 32'h3, r);
    t0 = cycleNow;
    @(negedge sys_clk);
    check("sample hold", 32'(sampleHold), 32'h1);
    check("first trial", 32'(dacCode), 32'h200);
    axi_rd(1'h0, OFS_CONTROL_A, d, r);
    check("go running", 32'(d[CA_GO_BIT]), 32'h1);
    n = 0;
    while (d[CA_GO_BIT] === 1'h1 && n < 2000) begin
      axi_rd(1'h0, OFS_CONTROL_A, d, r);
      n++;
    end
    n = cycleNow - t0;
    check("go cleared", 32'(d[CA_GO_BIT]), 32'h0);
    check("duration", 32'(n >= 10 * p && n <= 12 * p + 12), 32'h1);
    rd_chk(1'h0, OFS_RESULT_HIGH, 32'(hi), "result high");
    rd_chk(1'h0, OFS_RESULT_LOW, 32'(lo), "result low");
    repeat (20) @(posedge sys_clk);
    rd_chk(1'h1, OFS_DONE_FLAG, 32'h1, "flag read");
    axi_wr(1'h1, OFS_DONE_FLAG, 32'h0, r);
    @(negedge sys_clk);
    check("flag cleared", 32'(conversionDoneFlag), 32'h0);
  endtask

  // Abort by go and by enable, results keep the previous (zero) value
  task automatic abort_case();
    logic [1:0] r;
    compareIn <= 1'h1;
    axi_wr(1'h0, OFS_CONTROL_B, 32'h14, r);
    axi_wr(1'h0, OFS_CONTROL_A, 32'h3, r);
    repeat (30) @(posedge sys_clk);
    axi_wr(1'h0, OFS_CONTROL_A, 32'h1, r);
    repeat (60) @(posedge sys_clk);
    rd_chk(1'h0, OFS_CONTROL_A, 32'h1, "go after abort");
    rd_chk(1'h0, OFS_RESULT_LOW, 32'h0, "kept result");
    check("no flag on abort", 32'(conversionDoneFlag), 32'h0);
    axi_wr(1'h0, OFS_CONTROL_A, 32'h3, r);
    repeat (30) @(posedge sys_clk);
    axi_wr(1'h0, OFS_CONTROL_A, 32'h0, r);
    repeat (120) @(posedge sys_clk);
    check("power off", 32'(analogPower), 32'h0);
    check("hold off", 32'(sampleHold), 32'h0);
    check("no flag on disable", 32'(conversionDoneFlag), 32'h0);
    rd_chk(1'h0, OFS_RESULT_LOW, 32'h0, "kept after disable");
  endtask

  // Register map, masks, routing and reference codes
  task automatic reg_case();
    logic [5:0] codes [5] = '{6'h00, 6'h06, 6'h07, 6'h1F, 6'h3F};
    logic [31:0] d;
    logic [1:0] r;
    rd_chk(1'h0, OFS_CONTROL_A, 32'(CONTROL_A_RESET), "control A reset");
    rd_chk(1'h0, OFS_CONTROL_B, 32'(CONTROL_B_RESET), "control B reset");
    check("flag reset", 32'(conversionDoneFlag), 32'h0);
    axi_wr(1'h0, OFS_CONTROL_B, 32'hFF, r);
    rd_chk(1'h0, OFS_CONTROL_B, 32'h77, "control B mask");
    axi_wr(1'h0, OFS_CONTROL_A, 32'h2, r);
    rd_chk(1'h0, OFS_CONTROL_A, 32'h0, "go while off");
    for (int i = 0; i < 5; i++) begin
      axi_wr(1'h0, OFS_CONTROL_A, 32'(codes[i]) << CA_CHAN_LSB | 32'h1, r);
      @(negedge sys_clk);
      check("route", 32'(channelRoute), 32'(codes[i]));
      check("route valid", 32'(channelValid), 32'(i < 4));
      check("small route valid", 32'(smallValid), 32'(i == 0 || i == 3));
      check("power on", 32'(analogPower), 32'h1);
    end
    for (int i = 0; i < 4; i++) begin
      axi_wr(1'h0, OFS_CONTROL_B, 32'(i), r);
      @(negedge sys_clk);
      check("reference", 32'(referenceSelect), 32'(i));
    end
    axi_rd(1'h1, 4'h4, d, r);
    check("unmapped resp", 32'(r), 32'(RESP_SLVERR));
    check("unmapped data", d, 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (20) @(posedge sys_clk);
    rstn <= 1'h1;
    reg_case();
    compareIn <= 1'h1;
    conv_case(CLK_DIV8, 1'h1, 8, 8'h03, 8'hFF);
    conv_case(CLK_DIV16, 1'h1, 16, 8'h03, 8'hFF);
    conv_case(CLK_DIV32, 1'h1, 32, 8'h03, 8'hFF);
    conv_case(CLK_DIV64, 1'h1, 64, 8'h03, 8'hFF);
    conv_case(3'h3, 1'h0, 8 * RC_DIVIDE, 8'hFF, 8'hC0);
    compareIn <= 1'h0;
    conv_case(3'h7, 1'h1, 8 * RC_DIVIDE, 8'h00, 8'h00);
    abort_case();
    close_out();
  end
endmodule // adc_conversion_control_tb_top
